// *** hw/gic_cfg.svh ***
`ifndef GIC_CFG_SVH
`define GIC_CFG_SVH
// register offsets (word indices, byte addresses are the indices times four)
`define GIC_IDX_DATA_ST 8'h0A
`define GIC_IDX_EVT_ST 8'h09
`define GIC_IDX_DATA_EN 8'h15
`define GIC_IDX_PIN_CFG 8'h16
`define GIC_IDX_MAP_A 8'h17
`define GIC_IDX_MAP_B 8'h19
`define GIC_IDX_MODE 8'h21
`define GIC_IDX_SRC_EN 8'h30
`define GIC_IDX_PWR 8'h31
// field positions
`define GIC_BIT_DATA_EN 7
`define GIC_BIT_CLR 7
`define GIC_BIT_POL_A 0
`define GIC_BIT_OD_A 1
`define GIC_BIT_POL_B 2
`define GIC_BIT_OD_B 3
// reset values
`define GIC_RST_PIN_CFG 4'h5
`define GIC_RST_MODE 4'h0
// mode codes
`define GIC_MODE_NL0 4'h0
`define GIC_MODE_NL1 4'h8
`define GIC_MODE_LT0 4'h7
`define GIC_MODE_LT1 4'hF
// clock and hold times
`define GIC_CLK_HZ 100000000
`define GIC_T_NEWDATA_US 300
`define GIC_T_250US 250
`define GIC_T_500US 500
`define GIC_T_1MS_US 1000
`define GIC_T_12P5MS_US 12500
`define GIC_T_25MS_US 25000
`define GIC_T_50MS_US 50000
`define GIC_T_250MS_US 250000
`endif

// *** hw/gic_pkg.sv ***
package gic_pkg;
  typedef enum logic [1:0] {
    GIC_NONLATCH,
    GIC_LATCH,
    GIC_TIMED
  } gic_mode_e;
  typedef logic [2:0] gic_src_t;
endpackage

// *** hw/gic_top.sv ***
`timescale 1ns/100ps
`include "gic_cfg.svh"
// Summary of operation
// - three independently enabled engines set status and drive mapped pins
// - each pin is OR of sources mapped to it
// - status sets only when a new rate word is stored
// - disabling a source clears its status and pin share at once
// - four-bit mode: 0000/1000 non-latched, 0111/1111 latched, others timed
// - timed codes give 250ms..8s or 250us..50ms hold times
// - interrupt never clears while its condition holds, except by a latched software clear
// - non-latched clears when condition ends; new-data uses own time
// - latched stays set until software writes clear bit
// - latched cleared with condition true reasserts at next update
// - map registers route sources to pin a and pin b
// - polarity bit sets each pin's active level
// - driver bit selects open-drain or push-pull
// - new-data asserts after fresh z-rate sample stored
// - new-data self-clears after 280 to 400 microseconds
// - new-data always non-latched, ignores mode field
// - new-data enable bit and readable status flag
// - full function only in normal power mode
// - clear bit is write-only, reads zero
module gic_top
  import gic_pkg::*;
#(
  parameter int unsigned CLK_HZ = `GIC_CLK_HZ,
  parameter int unsigned NEWDATA_US = `GIC_T_NEWDATA_US,
  // 250 ms base unit; shorten for simulation
  parameter int unsigned SLOW_UNIT_US = `GIC_T_250MS_US
)(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // rate path
  input wire logic rate_upd_i,
  input wire logic [1:0] evt_cond_i,
  // pins
  input wire logic irq_pin_a_i,
  output logic irq_pin_a_o,
  output logic irq_pin_a_oe_n_o,
  input wire logic irq_pin_b_i,
  output logic irq_pin_b_o,
  output logic irq_pin_b_oe_n_o
);
  localparam int unsigned CYC_US = CLK_HZ / 1000000;
  localparam int unsigned ND_CYC = NEWDATA_US * CYC_US;
  localparam int unsigned CW = 40;
  localparam logic [CW-1:0] SLOW_CYC = CW'(64'(SLOW_UNIT_US) * 64'(CYC_US));

  function automatic logic [31:0] reg_addr(input logic [7:0] idx);
    reg_addr = {22'h0, idx, 2'b00};
  endfunction

  // hold cycles for a timed code; slow codes double per step
  function automatic logic [CW-1:0] hold_cyc(input logic [3:0] code);
    logic [CW-1:0] us;
    us = '0;
    case (code)
      4'h9: us = CW'(`GIC_T_250US);
      4'hA: us = CW'(`GIC_T_500US);
      4'hB: us = CW'(`GIC_T_1MS_US);
      4'hC: us = CW'(`GIC_T_12P5MS_US);
      4'hD: us = CW'(`GIC_T_25MS_US);
      4'hE: us = CW'(`GIC_T_50MS_US);
      default: us = '0;
    endcase
    if (code[3])
      hold_cyc = CW'(us * CW'(CYC_US));
    else
      hold_cyc = SLOW_CYC << (code[2:0] - 3'd1);
  endfunction

  // configuration registers
  logic data_en_r;
  logic [1:0] src_en_r;
  logic [3:0] pin_cfg_r;
  logic [2:0] map_a_r, map_b_r;
  logic [3:0] mode_r;
  logic normal_r;
  // status and timers
  logic [1:0] evt_st_r;
  logic data_st_r;
  logic [31:0] nd_cnt_r;
  logic [CW-1:0] hold_cnt_r [2];
  logic [31:0] prdata_r;

  wire logic wr_en = psel_i & penable_i & pwrite_i;
  wire logic rd_en = psel_i & penable_i & ~pwrite_i;
  wire logic hit_data_st = paddr_i == reg_addr(`GIC_IDX_DATA_ST);
  wire logic hit_evt_st = paddr_i == reg_addr(`GIC_IDX_EVT_ST);
  wire logic hit_data_en = paddr_i == reg_addr(`GIC_IDX_DATA_EN);
  wire logic hit_pin_cfg = paddr_i == reg_addr(`GIC_IDX_PIN_CFG);
  wire logic hit_map_a = paddr_i == reg_addr(`GIC_IDX_MAP_A);
  wire logic hit_map_b = paddr_i == reg_addr(`GIC_IDX_MAP_B);
  wire logic hit_mode = paddr_i == reg_addr(`GIC_IDX_MODE);
  wire logic hit_src_en = paddr_i == reg_addr(`GIC_IDX_SRC_EN);
  wire logic hit_pwr = paddr_i == reg_addr(`GIC_IDX_PWR);
  wire logic hit_any = hit_data_st | hit_evt_st | hit_data_en | hit_pin_cfg | hit_map_a
    | hit_map_b | hit_mode | hit_src_en | hit_pwr;
  // write-only trigger, never stored
  wire logic clr_wr = wr_en & hit_mode & pwdata_i[`GIC_BIT_CLR];

  gic_mode_e mode_sel;
  assign mode_sel = (mode_r == `GIC_MODE_NL0 || mode_r == `GIC_MODE_NL1) ? GIC_NONLATCH :
    (mode_r == `GIC_MODE_LT0 || mode_r == `GIC_MODE_LT1) ? GIC_LATCH : GIC_TIMED;

  // status sampled only on rate update, gated by normal mode
  wire logic upd = rate_upd_i & normal_r;
  wire logic [1:0] cond = evt_cond_i & src_en_r;
  logic [1:0] evt_nxt;
  logic [CW-1:0] hold_nxt [2];

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      evt_nxt[i] = evt_st_r[i];
      hold_nxt[i] = hold_cnt_r[i];
      if (hold_cnt_r[i] != '0)
        hold_nxt[i] = hold_cnt_r[i] - CW'(1);
      if (upd)
      begin
        if (cond[i])
        begin
          // assert or hold while condition true
          if (!evt_st_r[i])
            hold_nxt[i] = hold_cyc(mode_r);
          evt_nxt[i] = 1'b1;
        end
        else if (mode_sel == GIC_NONLATCH)
          evt_nxt[i] = 1'b0;
      end
      // timed release only once condition ended
      if (mode_sel == GIC_TIMED && evt_st_r[i] && hold_cnt_r[i] == CW'(1) && !cond[i])
        evt_nxt[i] = 1'b0;
      // latched: software clear; a same-cycle update with condition re-sets
      if (mode_sel == GIC_LATCH && clr_wr && !(upd && cond[i]))
        evt_nxt[i] = 1'b0;
      if (!src_en_r[i])
      begin
        evt_nxt[i] = 1'b0;
        hold_nxt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      data_en_r <= 1'b0;
      src_en_r <= 2'b00;
      pin_cfg_r <= `GIC_RST_PIN_CFG;
      map_a_r <= 3'h0;
      map_b_r <= 3'h0;
      mode_r <= `GIC_RST_MODE;
      normal_r <= 1'b1;
    end
    else if (wr_en)
    begin
      if (hit_data_en)
        data_en_r <= pwdata_i[`GIC_BIT_DATA_EN];
      if (hit_src_en)
        src_en_r <= pwdata_i[1:0];
      if (hit_pin_cfg)
        pin_cfg_r <= pwdata_i[3:0];
      if (hit_map_a)
        map_a_r <= pwdata_i[2:0];
      if (hit_map_b)
        map_b_r <= pwdata_i[2:0];
      if (hit_mode)
        mode_r <= pwdata_i[3:0];
      if (hit_pwr)
        normal_r <= pwdata_i[0];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      evt_st_r <= 2'b00;
      hold_cnt_r[0] <= '0;
      hold_cnt_r[1] <= '0;
    end
    else
    begin
      evt_st_r <= evt_nxt;
      hold_cnt_r[0] <= hold_nxt[0];
      hold_cnt_r[1] <= hold_nxt[1];
    end
  end

  // new-data pulse: fixed length, ignores mode field
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !data_en_r)
    begin
      data_st_r <= 1'b0;
      nd_cnt_r <= 32'h0000_0000;
    end
    else if (upd)
    begin
      data_st_r <= 1'b1;
      nd_cnt_r <= ND_CYC;
    end
    else if (nd_cnt_r != 32'h0000_0000)
    begin
      nd_cnt_r <= nd_cnt_r - 32'h0000_0001;
      if (nd_cnt_r == 32'h0000_0001)
        data_st_r <= 1'b0;
    end
  end

  // pins
  wire gic_src_t src = {evt_st_r, data_st_r};
  wire logic act_a = |(src & map_a_r);
  wire logic act_b = |(src & map_b_r);
  wire logic pol_a = pin_cfg_r[`GIC_BIT_POL_A];
  wire logic pol_b = pin_cfg_r[`GIC_BIT_POL_B];
  wire logic od_a = pin_cfg_r[`GIC_BIT_OD_A];
  wire logic od_b = pin_cfg_r[`GIC_BIT_OD_B];
  logic pin_a_r, pin_b_r, oe_a_n_r, oe_b_n_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      pin_a_r <= 1'b0;
      pin_b_r <= 1'b0;
      oe_a_n_r <= 1'b0;
      oe_b_n_r <= 1'b0;
    end
    else
    begin
      pin_a_r <= act_a ~^ pol_a;
      pin_b_r <= act_b ~^ pol_b;
      oe_a_n_r <= od_a & ~act_a;
      oe_b_n_r <= od_b & ~act_b;
    end
  end

  assign irq_pin_a_o = pin_a_r;
  assign irq_pin_b_o = pin_b_r;
  assign irq_pin_a_oe_n_o = oe_a_n_r;
  assign irq_pin_b_oe_n_o = oe_b_n_r;

  // wire levels read back; three stages, a level counts once stages two and three agree
  logic [2:0] sync_a_r, sync_b_r;
  logic lvl_a_r, lvl_b_r;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      sync_a_r <= 3'h0;
      sync_b_r <= 3'h0;
      lvl_a_r <= 1'b0;
      lvl_b_r <= 1'b0;
    end
    else
    begin
      sync_a_r <= {sync_a_r[1:0], irq_pin_a_i};
      sync_b_r <= {sync_b_r[1:0], irq_pin_b_i};
      if (sync_a_r[1] == sync_a_r[2])
        lvl_a_r <= sync_a_r[2];
      if (sync_b_r[1] == sync_b_r[2])
        lvl_b_r <= sync_b_r[2];
    end
  end

  // read mux; wire levels sit read-only in bits 5:4 of the pin register
  wire logic [31:0] rd_val =
    hit_data_st ? {31'h0, data_st_r} :
    hit_evt_st ? {30'h0, evt_st_r} :
    hit_data_en ? {24'h0, data_en_r, 7'h0} :
    hit_pin_cfg ? {26'h0, lvl_b_r, lvl_a_r, pin_cfg_r} :
    hit_map_a ? {29'h0, map_a_r} :
    hit_map_b ? {29'h0, map_b_r} :
    hit_mode ? {28'h0, mode_r} :
    hit_src_en ? {30'h0, src_en_r} :
    hit_pwr ? {31'h0, normal_r} : 32'h0000_0000;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      prdata_r <= 32'h0000_0000;
    else if (psel_i & ~penable_i & ~pwrite_i)
      prdata_r <= rd_val;
  end

  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = (rd_en | wr_en) & ~hit_any;

  // assertions
  property p_nd_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i) data_en_r && upd |=> data_st_r;
  endproperty
  a_nd_set: assert property (p_nd_set) else $error("new data flag not set");
  property p_dis_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !src_en_r[0] |=> !evt_st_r[0];
  endproperty
  a_dis_clr: assert property (p_dis_clr) else $error("disabled source still set");
  // a latched clear may drop a flag whose condition holds; it returns at next update
  property p_hold_cond;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      evt_st_r[1] && cond[1] && src_en_r[1] && !upd && !(mode_sel == GIC_LATCH && clr_wr)
      |=> evt_st_r[1] || !src_en_r[1];
  endproperty
  a_hold_cond: assert property (p_hold_cond) else $error("cleared while condition true");
  property p_no_upd;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !evt_st_r[0] && !upd |=> !evt_st_r[0];
  endproperty
  a_no_upd: assert property (p_no_upd) else $error("status set without update");
  property p_pin_a;
    @(posedge clk_sys_i) disable iff (!rst_n_i) 1 |=> pin_a_r == ($past(act_a) ~^ $past(pol_a));
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a level wrong");
  property p_od;
    @(posedge clk_sys_i) disable iff (!rst_n_i) od_b && !act_b ##1 od_b |-> oe_b_n_r;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives idle");
  property p_latch;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      mode_sel == GIC_LATCH && evt_st_r[0] && src_en_r[0] && !clr_wr |=> evt_st_r[0]
      || !src_en_r[0] || mode_sel != GIC_LATCH;
  endproperty
  a_latch: assert property (p_latch) else $error("latched flag lost");
  property p_nl;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      mode_sel == GIC_NONLATCH && upd && !cond[0] |=> !evt_st_r[0];
  endproperty
  a_nl: assert property (p_nl) else $error("non latched not cleared");
  c_nd: cover property (@(posedge clk_sys_i) data_st_r ##1 !data_st_r);
  c_latch: cover property (@(posedge clk_sys_i) mode_sel == GIC_LATCH && clr_wr && evt_st_r[0]);
  c_timed: cover property (@(posedge clk_sys_i) mode_sel == GIC_TIMED && hold_cnt_r[0] == CW'(1));
  c_dis: cover property (@(posedge clk_sys_i) !src_en_r[0] && evt_st_r[0]);
  c_od: cover property (@(posedge clk_sys_i) od_b && oe_b_n_r);
  property p_pin_b;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      1 |=> pin_b_r == ($past(act_b) ~^ $past(pol_b));
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b level wrong");
  property p_oe_a;
    @(posedge clk_sys_i) disable iff (!rst_n_i) !od_a ##1 !od_a |-> !oe_a_n_r;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("push pull pin a not driven");
  property p_nd_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      data_en_r && !upd && nd_cnt_r == 32'h0000_0001 |=> !data_st_r;
  endproperty
  a_nd_clr: assert property (p_nd_clr) else $error("new data flag not released");
  property p_timed;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      mode_sel == GIC_TIMED && evt_st_r[0] && hold_cnt_r[0] == CW'(1) && !cond[0]
      |=> !evt_st_r[0];
  endproperty
  a_timed: assert property (p_timed) else $error("timed flag not released");
  property p_latch_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      mode_sel == GIC_LATCH && clr_wr && !(upd && cond[0]) |=> !evt_st_r[0];
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latched flag not cleared");
endmodule // gic_top

// *** testbench/gic_pin_host.sv ***
`timescale 1ns/100ps
// host side of one pin; the external resistor pulls to the inactive level
module gic_pin_host (
  // pin driver
  input wire logic lvl_i,
  input wire logic oe_n_i,
  input wire logic act_hi_i,
  // resolved wire
  output logic wire_o
);
  assign wire_o = oe_n_i ? ~act_hi_i : lvl_i;
endmodule // gic_pin_host

// *** testbench/tb.sv ***
`timescale 1ns/100ps
`include "gic_cfg.svh"
module tb;
  logic clk_sys_i, rst_n_i, psel, pen, pwr, upd, samp;
  logic [31:0] paddr, pwdata, prdata;
  logic prdy, perr, pa, pa_oe_n, pb, pb_oe_n, wa, wb;
  logic [1:0] cond;
  logic [3:0] cfg, code, ep;
  logic [7:0] rnd;
  logic [32:0] er;
  logic [32:0] q_rd[$];
  logic [3:0] q_pin[$];
  int n_errors, check_count, i;
  // short hold units keep the timed and new-data checks within a few hundred cycles
  gic_top #(.NEWDATA_US(3), .SLOW_UNIT_US(2)) dut_u (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
    .rate_upd_i(upd), .evt_cond_i(cond), .irq_pin_a_i(wa), .irq_pin_a_o(pa),
    .irq_pin_a_oe_n_o(pa_oe_n), .irq_pin_b_i(wb), .irq_pin_b_o(pb),
    .irq_pin_b_oe_n_o(pb_oe_n));
  gic_pin_host host_a (.lvl_i(pa), .oe_n_i(pa_oe_n), .act_hi_i(cfg[0]), .wire_o(wa));
  gic_pin_host host_b (.lvl_i(pb), .oe_n_i(pb_oe_n), .act_hi_i(cfg[2]), .wire_o(wb));
  initial
  begin
    clk_sys_i = 0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic test_done;
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    psel <= 1;
    pwr <= w;
    paddr <= {22'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clk_sys_i);
      if (prdy === 1'b1)
        break;
    end
    psel <= 0;
    pen <= 0;
    if (k == 16)
    begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [32:0] e);
    q_rd.push_back(e);
    bus(idx, 1'b0, 32'h0);
  endtask
  task automatic pin(input logic [3:0] e);
    repeat (2) @(posedge clk_sys_i);
    q_pin.push_back(e);
    samp <= 1;
    @(posedge clk_sys_i);
    samp <= 0;
  endtask
  // status settles one edge after the strobe, the pins one edge later
  task automatic pulse(input logic [1:0] c);
    @(posedge clk_sys_i);
    cond <= c;
    upd <= 1;
    @(posedge clk_sys_i);
    upd <= 0;
    repeat (3) @(posedge clk_sys_i);
  endtask
  always @(posedge clk_sys_i)
  begin
    if (psel && pen && !pwr && prdy === 1'b1)
    begin
      er = q_rd.pop_front();
      cmp(er, {perr, prdata});
    end
    if (samp)
    begin
      ep = q_pin.pop_front();
      cmp({29'h0, ep}, {29'h0, pa_oe_n, wa, pb_oe_n, wb});
    end
  end
  initial
  begin
    rst_n_i = 0;
    {psel, pen, pwr, upd, samp, cond} = '0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cfg = 4'h5;
    n_errors = 0;
    check_count = 0;
    rnd = 8'hd;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1;
    rd(`GIC_IDX_PIN_CFG, 33'h5);
    rd(`GIC_IDX_MODE, 33'h0);
    rd(8'h3F, {1'b1, 32'h0});
    pin(4'h0);
    wr(`GIC_IDX_SRC_EN, 32'h3);
    wr(`GIC_IDX_MAP_A, 32'h2);
    wr(`GIC_IDX_MAP_B, 32'h4);
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      pulse(rnd[1:0]);
      rd(`GIC_IDX_EVT_ST, {31'h0, rnd[1:0]});
      pin({1'b0, rnd[0], 1'b0, rnd[1]});
    end
    cond <= ~rnd[1:0];
    rd(`GIC_IDX_EVT_ST, {31'h0, rnd[1:0]});
    wr(`GIC_IDX_MAP_B, 32'h6);
    pulse(2'b01);
    pin(4'h5);
    pulse(2'b11);
    wr(`GIC_IDX_SRC_EN, 32'h1);
    rd(`GIC_IDX_EVT_ST, 33'h1);
    wr(`GIC_IDX_SRC_EN, 32'h0);
    rd(`GIC_IDX_EVT_ST, 33'h0);
    wr(`GIC_IDX_SRC_EN, 32'h3);
    rd(`GIC_IDX_EVT_ST, 33'h0);
    pulse(2'b00);
    for (i = 0; i < 2; i++)
    begin
      code = i ? 4'hF : 4'h7;
      wr(`GIC_IDX_MODE, {28'h0, code});
      pulse(2'b01);
      pulse(2'b00);
      rd(`GIC_IDX_EVT_ST, 33'h1);
      wr(`GIC_IDX_MODE, {24'h0, 4'h8, code});
      rd(`GIC_IDX_EVT_ST, 33'h0);
      rd(`GIC_IDX_MODE, {29'h0, code});
      pulse(2'b01);
      wr(`GIC_IDX_MODE, {24'h0, 4'h8, code});
      pulse(2'b01);
      rd(`GIC_IDX_EVT_ST, 33'h1);
      pulse(2'b00);
      wr(`GIC_IDX_MODE, {24'h0, 4'h8, code});
    end
    // latched mode still in force: new-data must self-clear regardless
    wr(`GIC_IDX_DATA_EN, 32'h80);
    wr(`GIC_IDX_MAP_A, 32'h1);
    pulse(2'b00);
    rd(`GIC_IDX_DATA_ST, 33'h1);
    pin(4'h4);
    repeat (190) @(posedge clk_sys_i);
    rd(`GIC_IDX_DATA_ST, 33'h1);
    repeat (200) @(posedge clk_sys_i);
    rd(`GIC_IDX_DATA_ST, 33'h0);
    wr(`GIC_IDX_DATA_EN, 32'h0);
    wr(`GIC_IDX_MODE, 32'h1);
    pulse(2'b01);
    pulse(2'b00);
    rd(`GIC_IDX_EVT_ST, 33'h1);
    repeat (140) @(posedge clk_sys_i);
    rd(`GIC_IDX_EVT_ST, 33'h1);
    repeat (80) @(posedge clk_sys_i);
    rd(`GIC_IDX_EVT_ST, 33'h0);
    wr(`GIC_IDX_MODE, 32'h0);
    wr(`GIC_IDX_PWR, 32'h0);
    pulse(2'b01);
    rd(`GIC_IDX_EVT_ST, 33'h0);
    wr(`GIC_IDX_PWR, 32'h1);
    pulse(2'b01);
    wr(`GIC_IDX_MAP_A, 32'h2);
    wr(`GIC_IDX_MAP_B, 32'h4);
    // pin a active, pin b idle, every polarity and driver mix
    for (i = 0; i < 16; i++)
    begin
      wr(`GIC_IDX_PIN_CFG, {28'h0, i[3:0]});
      cfg <= i[3:0];
      pin({1'b0, i[0], i[3], ~i[2]});
    end
    // read-back passes three stages before the register shows it
    repeat (4) @(posedge clk_sys_i);
    rd(`GIC_IDX_PIN_CFG, 33'h1F);
    test_done();
  end
endmodule // tb
